// [bench/ssrl_cpu_model.sv]
// Purpose: processor model that kicks the watchdog input
// Assumes: kick_run low freezes the kick level
// Notes:   toggles every 20 cycles, well inside the shortened timeout
`timescale 1ns/1ps
`default_nettype none
module ssrl_cpu_model (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // control and kick
  input  wire logic kick_run,
  output logic      watchdog_kick_input
);
  logic [4:0] gap_q;
  // each level stands 20 cycles, above the 10 cycle minimum
  // one toggle per pass of the main loop, not a pulse
  always_ff @(posedge core_clk) begin
    if (reset) begin
      gap_q               <= 5'h0;
      watchdog_kick_input <= 1'b0;
    end else if (kick_run) begin
      gap_q <= (gap_q == 5'h13) ? 5'h0 : gap_q + 5'h1;
      if (gap_q == 5'h13) watchdog_kick_input <= ~watchdog_kick_input;
    end
  end
endmodule : ssrl_cpu_model
`default_nettype wire

// [bench/test_ssrl_top.sv]
// Purpose: self-checking bench for the supervisor reset logic
// Assumes: all three builds share one stimulus, shortened counts
// Notes:   push-pull pin value 3'h1 is reset asserted, 3'h7 released
`timescale 1ns/1ps
`default_nettype none
module test_ssrl_top;
  import ssrl_pkg::*;
  localparam int HOLD = 20;
  localparam int KTO  = 50;
  localparam int DEB  = 3;
  localparam logic [2:0] ON  = 3'h1;
  localparam logic [2:0] OFF = 3'h7;
  logic      core_clk, reset, manual_reset_input, watchdog_enable, kick_run;
  logic      watchdog_kick_input, backup_active_flag, out_from_cell;
  ssrl_cmp_t cmp_in;
  ssrl_pin_t reset_pin;
  ssrl_pin_t hod_pin, lod_pin;
  int        error_cnt, compares;
  //////////////////////////////////////////////////////////////////////////
  ssrl_top #(.HOLD_CYC(HOLD), .KICK_TO_CYC(KTO), .DEB_CYC(DEB)) dut (
    .core_clk(core_clk), .reset(reset), .cmp_in(cmp_in),
    .manual_reset_input(manual_reset_input), .watchdog_kick_input(watchdog_kick_input),
    .watchdog_enable(watchdog_enable), .reset_pin(reset_pin),
    .backup_active_flag(backup_active_flag), .out_from_cell(out_from_cell));
  ssrl_cpu_model cpu (.core_clk(core_clk), .reset(reset), .kick_run(kick_run),
    .watchdog_kick_input(watchdog_kick_input));
  ssrl_top #(.VARIANT(SSRL_OUT_HIGH_OD), .HOLD_CYC(HOLD), .KICK_TO_CYC(KTO), .DEB_CYC(DEB)) dut_hod (
    .core_clk(core_clk), .reset(reset), .cmp_in(cmp_in),
    .manual_reset_input(manual_reset_input), .watchdog_kick_input(watchdog_kick_input),
    .watchdog_enable(watchdog_enable), .reset_pin(hod_pin),
    .backup_active_flag(), .out_from_cell());
  ssrl_top #(.VARIANT(SSRL_OUT_LOW_OD), .HOLD_CYC(HOLD), .KICK_TO_CYC(KTO), .DEB_CYC(DEB)) dut_lod (
    .core_clk(core_clk), .reset(reset), .cmp_in(cmp_in),
    .manual_reset_input(manual_reset_input), .watchdog_kick_input(watchdog_kick_input),
    .watchdog_enable(watchdog_enable), .reset_pin(lod_pin),
    .backup_active_flag(), .out_from_cell());
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic check(input logic [2:0] seen, input logic [2:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : check
  task automatic end_of_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  // bounded wait; running out counts a mismatch and ends the run
  task automatic wait_pin(input logic [2:0] exp, input int lim);
    for (int i = 0; i < lim && reset_pin !== exp; i++) cyc(1);
    if (reset_pin !== exp) begin
      check(reset_pin, exp, "pin wait ran out");
      end_of_test();
    end
  endtask : wait_pin
  // the open-drain builds run in step with dut
  task automatic variant_check(input logic on);
    check(hod_pin, on ? 3'h4 : 3'h1, "high open-drain pin");
    check(lod_pin, on ? 3'h1 : 3'h4, "low open-drain pin");
  endtask : variant_check
  //////////////////////////////////////////////////////////////////////////
  task automatic set_cause(input int which, input logic on);
    case (which)
      0: cmp_in.main_below_trip = on;
      1: cmp_in.aux_low = on;
      default: manual_reset_input = ~on;
    endcase
  endtask : set_cause
  task automatic cause_run(input int which);
    set_cause(which, 1'b1);
    cyc(DEB + 6);
    check(reset_pin, ON, "cause not seen");
    variant_check(1'b1);
    cyc(40);
    check(reset_pin, ON, "cause dropped");
    set_cause(which, 1'b0);
    cyc(HOLD - 1);
    check(reset_pin, ON, "hold short");
    wait_pin(OFF, 12);
    variant_check(1'b0);
  endtask : cause_run
  task automatic glitch_run;
    manual_reset_input = 1'b0;
    cyc(DEB - 2);
    manual_reset_input = 1'b1;
    cyc(10);
    check(reset_pin, OFF, "glitch reset");
  endtask : glitch_run
  task automatic watchdog_run;
    watchdog_enable = 1'b1;
    kick_run = 1'b1;
    cyc(4 * KTO);
    check(reset_pin, OFF, "kicked yet reset");
    kick_run = 1'b0;
    // last kick may still be in the filter: one kick gap plus filter delay of slack
    wait_pin(ON, KTO + 30);
    cyc(HOLD - 2);
    check(reset_pin, ON, "pulse short");
    wait_pin(OFF, 10);
    wait_pin(ON, KTO + 10);
    kick_run = 1'b1;
    wait_pin(OFF, HOLD + 10);
    cyc(2 * KTO);
    check(reset_pin, OFF, "resumed kicks ignored");
    watchdog_enable = 1'b0;
  endtask : watchdog_run
  task automatic backup_run;
    cmp_in.main_below_trip = 1'b1;
    cyc(4);
    check({1'b0, backup_active_flag, out_from_cell}, 3'h0, "backup w/o cell");
    cmp_in.cell_above_main = 1'b1;
    cyc(4);
    check({1'b0, backup_active_flag, out_from_cell}, 3'h3, "no backup");
    cmp_in.cell_above_main = 1'b0;
    cyc(4);
    check({1'b0, backup_active_flag, out_from_cell}, 3'h3, "hysteresis");
    cmp_in.main_above_cell = 1'b1;
    cyc(4);
    check({1'b0, backup_active_flag, out_from_cell}, 3'h0, "no return");
    cmp_in = '{main_below_trip: 1'b1, cell_above_main: 1'b1, default: 1'b0};
    cyc(4);
    check({1'b0, backup_active_flag, out_from_cell}, 3'h3, "no second backup");
    cmp_in.main_below_trip = 1'b0;
    cyc(4);
    check({1'b0, backup_active_flag, out_from_cell}, 3'h0, "cell kept above trip");
    cmp_in = '0;
    wait_pin(OFF, HOLD + 12);
  endtask : backup_run
  task automatic reset_run;
    reset = 1'b1;
    cyc(2);
    check(reset_pin, ON, "pin free while logic held");
    variant_check(1'b1);
    reset = 1'b0;
    cyc(1);
    check(reset_pin, ON, "no reset after logic reset");
    variant_check(1'b1);
    wait_pin(OFF, HOLD + 12);
    variant_check(1'b0);
  endtask : reset_run
  //////////////////////////////////////////////////////////////////////////
  initial begin
    error_cnt = 0;
    compares = 0;
    reset = 1'b1;
    // power-up with only the cell looking good
    cmp_in = '{main_below_trip: 1'b1, cell_above_main: 1'b1, default: 1'b0};
    manual_reset_input = 1'b1;
    watchdog_enable = 1'b0;
    kick_run = 1'b0;
    cyc(8);
    reset = 1'b0;
    cyc(6);
    check(reset_pin, ON, "no reset at start");
    variant_check(1'b1);
    check({1'b0, backup_active_flag, out_from_cell}, 3'h0, "cell startup");
    cmp_in = '0;
    wait_pin(OFF, HOLD + 12);
    for (int w = 0; w < 3; w++) cause_run(w);
    glitch_run();
    watchdog_run();
    backup_run();
    reset_run();
    end_of_test();
  end
endmodule : test_ssrl_top
`default_nettype wire

// [rtl/ssrl_filter.sv]
// Purpose: level filter, new level accepted after it stands a number of cycles
// Assumes: input synchronous to core_clk
// Notes:   used for the manual input debounce and the kick qualification
`timescale 1ns/1ps
`default_nettype none
module ssrl_filter #(
  parameter int unsigned CYCLES   = 10,
  parameter logic        INIT_VAL = 1'b1
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // data
  input  wire logic raw_in,
  output logic      clean_q
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          clean_d;

  always_comb begin
    cnt_d   = '0;
    clean_d = clean_q;
    if (raw_in != clean_q) begin
      if (cnt_q >= CW'(CYCLES - 1)) begin
        clean_d = raw_in;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_q   <= '0;
      clean_q <= INIT_VAL;
    end else begin
      cnt_q   <= cnt_d;
      clean_q <= clean_d;
    end
  end
endmodule : ssrl_filter
`default_nettype wire

// [rtl/ssrl_pkg.sv]
// Purpose: shared constants and types for the supply supervisor reset logic
// Assumes: core_clk at 100 MHz
// Notes:   times are kept in their own unit, cycle counts derived from them
package ssrl_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 10;
  // hold period minimum, in ms
  localparam int unsigned HOLD_PERIOD_MS  = 150;
  // kick timeout, in ms (typical figure)
  localparam int unsigned KICK_TIMEOUT_MS = 1600;
  // least kick level hold, in ns
  localparam int unsigned KICK_MIN_NS     = 100;
  // manual input debounce interval, in us
  localparam int unsigned DEBOUNCE_US     = 1;

  // least times round up to whole cycles
  localparam int unsigned HOLD_CYCLES     = (HOLD_PERIOD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned KICK_TO_CYCLES  = (KICK_TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned KICK_MIN_CYCLES = (KICK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEB_CYCLES      = (DEBOUNCE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // reset output variants
  typedef enum logic [1:0] {
    SSRL_OUT_HIGH_OD = 2'h0,
    SSRL_OUT_LOW_PP  = 2'h1,
    SSRL_OUT_LOW_OD  = 2'h2
  } ssrl_variant_t;

  // comparator decisions from the analog front end
  typedef struct packed {
    logic main_below_trip;
    logic cell_above_main;
    logic main_above_cell;
    logic aux_low;
  } ssrl_cmp_t;

  // reset pin as three signals
  typedef struct packed {
    logic level;
    logic out;
    logic oe;
  } ssrl_pin_t;

  typedef enum logic [2:0] {
    SSRL_ST_ACTIVE = 3'h1,
    SSRL_ST_HOLD   = 3'h2,
    SSRL_ST_RUN    = 3'h4
  } ssrl_state_t;

endpackage : ssrl_pkg

// [rtl/ssrl_top.sv]
// Purpose: reset generation, watchdog and backup switchover decisions
// Assumes: comparator results arrive as synchronous levels on core_clk
// Notes:   long counts are parameters so simulation can shorten them
`timescale 1ns/1ps
`default_nettype none

module ssrl_top
  import ssrl_pkg::*;
#(
  parameter ssrl_variant_t VARIANT     = SSRL_OUT_LOW_PP,
  parameter int unsigned   HOLD_CYC    = HOLD_CYCLES,
  parameter int unsigned   KICK_TO_CYC = KICK_TO_CYCLES,
  parameter int unsigned   DEB_CYC     = DEB_CYCLES
) (
  // clock and reset
  input  wire logic      core_clk,
  input  wire logic      reset,
  // comparator decisions
  input  wire ssrl_cmp_t cmp_in,
  // user inputs
  input  wire logic      manual_reset_input,
  input  wire logic      watchdog_kick_input,
  input  wire logic      watchdog_enable,
  // reset pin
  output ssrl_pin_t      reset_pin,
  // supply control
  output logic           backup_active_flag,
  output logic           out_from_cell
);
  localparam int unsigned HW = $clog2(HOLD_CYC + 1);
  localparam int unsigned KW = $clog2(KICK_TO_CYC + 1);

  ////////////////////////////////////////////////////////////////////////
  // input conditioning
  logic mr_clean;
  logic kick_clean;

  // the pad pull-up is modeled by resetting the filter to high
  ssrl_filter #(.CYCLES(DEB_CYC), .INIT_VAL(1'b1)) u_mr_filt (
    .core_clk (core_clk),
    .reset    (reset),
    .raw_in   (manual_reset_input),
    .clean_q  (mr_clean)
  );

  // a kick counts only once its new level has stood the minimum time, so a
  // short spike on the line can neither clear the timer nor fake an edge later
  ssrl_filter #(.CYCLES(KICK_MIN_CYCLES), .INIT_VAL(1'b0)) u_kick_filt (
    .core_clk (core_clk),
    .reset    (reset),
    .raw_in   (watchdog_kick_input),
    .clean_q  (kick_clean)
  );

  ////////////////////////////////////////////////////////////////////////
  // reset sequencing
  ssrl_state_t   st_q, st_d;
  logic [HW-1:0] hold_q, hold_d;
  logic [KW-1:0] wd_q, wd_d;
  logic          kick_prev_q, kick_prev_d;
  logic          wd_expire;
  logic          cause;
  logic          rst_d;
  logic          rst_q;

  // backup mode does not mask the manual, aux or kick inputs; main low holds reset anyway
  assign cause     = cmp_in.main_below_trip | ~mr_clean | cmp_in.aux_low;
  assign wd_expire = watchdog_enable && (wd_q >= KW'(KICK_TO_CYC - 1));

  always_comb begin
    st_d        = st_q;
    hold_d      = hold_q;
    wd_d        = wd_q;
    kick_prev_d = kick_clean;
    case (st_q)
      SSRL_ST_ACTIVE: begin
        wd_d   = '0;
        hold_d = '0;
        if (!cause) begin
          st_d = SSRL_ST_HOLD;
        end
      end
      SSRL_ST_HOLD: begin
        wd_d = '0;
        if (cause) begin
          st_d   = SSRL_ST_ACTIVE;
          hold_d = '0;
        end else if (hold_q >= HW'(HOLD_CYC - 1)) begin
          st_d   = SSRL_ST_RUN;
          hold_d = '0;
        end else begin
          hold_d = hold_q + 1'b1;
        end
      end
      SSRL_ST_RUN: begin
        hold_d = '0;
        if (cause) begin
          st_d = SSRL_ST_ACTIVE;
          wd_d = '0;
        end else if (wd_expire) begin
          st_d = SSRL_ST_HOLD;
          wd_d = '0;
        end else if (kick_clean != kick_prev_q || !watchdog_enable) begin
          wd_d = '0;
        end else begin
          wd_d = wd_q + 1'b1;
        end
      end
      default: begin
        st_d   = SSRL_ST_ACTIVE;
        hold_d = '0;
        wd_d   = '0;
      end
    endcase
    rst_d = (st_d != SSRL_ST_RUN);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q        <= SSRL_ST_ACTIVE;
      hold_q      <= '0;
      wd_q        <= '0;
      kick_prev_q <= 1'b0;
      rst_q       <= 1'b1;
    end else begin
      st_q        <= st_d;
      hold_q      <= hold_d;
      wd_q        <= wd_d;
      kick_prev_q <= kick_prev_d;
      rst_q       <= rst_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output pin variants
  ssrl_pin_t pin_d;

  always_comb begin
    case (VARIANT)
      SSRL_OUT_HIGH_OD: pin_d = '{level: rst_d, out: 1'b0, oe: ~rst_d};
      SSRL_OUT_LOW_OD:  pin_d = '{level: ~rst_d, out: 1'b0, oe: rst_d};
      default:          pin_d = '{level: ~rst_d, out: ~rst_d, oe: 1'b1};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // backup switchover
  logic main_valid_q, main_valid_d;
  logic bk_q, bk_d;

  always_comb begin
    // no backup until main has once been above trip
    main_valid_d = main_valid_q | ~cmp_in.main_below_trip;
    bk_d         = bk_q;
    if (!cmp_in.main_below_trip || !main_valid_q) begin
      bk_d = 1'b0;
    end else if (cmp_in.cell_above_main) begin
      bk_d = 1'b1;
    end else if (cmp_in.main_above_cell) begin
      bk_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      main_valid_q       <= 1'b0;
      bk_q               <= 1'b0;
      // the active-high build floats its pin to show reset while the logic is held
      reset_pin          <= (VARIANT == SSRL_OUT_HIGH_OD) ? 3'h4 : 3'h1;
      backup_active_flag <= 1'b0;
      out_from_cell      <= 1'b0;
    end else begin
      main_valid_q       <= main_valid_d;
      bk_q               <= bk_d;
      reset_pin          <= pin_d;
      backup_active_flag <= bk_d;
      out_from_cell      <= bk_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // check helpers
  // cycles that reset has stood since the last active cause, saturating;
  // kept apart from hold_q so the stretch check does not lean on the counter it guards
  logic [HW-1:0] stretch_q;
  logic [HW-1:0] stretch_d;

  always_comb begin
    stretch_d = stretch_q;
    if (cause || !rst_q) begin
      stretch_d = '0;
    end else if (stretch_q < HW'(HOLD_CYC)) begin
      stretch_d = stretch_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      stretch_q <= '0;
    end else begin
      stretch_q <= stretch_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  AST_CAUSE_HOLDS: assert property (@(posedge core_clk) disable iff (reset)
    cause |=> rst_q) else $error("reset released while cause active");
  AST_HOLD_LEN: assert property (@(posedge core_clk) disable iff (reset)
    (st_q == SSRL_ST_HOLD && $past(st_q) != SSRL_ST_HOLD) |-> rst_q [*8])
    else $error("hold period cut short");
  AST_EXPIRE_PULSE: assert property (@(posedge core_clk) disable iff (reset)
    (st_q == SSRL_ST_RUN && wd_expire && !cause) |=> st_q == SSRL_ST_HOLD)
    else $error("watchdog expiry gave no pulse");
  AST_WD_CLEAR: assert property (@(posedge core_clk) disable iff (reset)
    rst_q |-> wd_q == '0) else $error("watchdog counted during reset");
  AST_MR_LOW: assert property (@(posedge core_clk) disable iff (reset)
    !mr_clean |=> ##1 rst_q) else $error("manual low did not hold reset");
  AST_BK_NEEDS_LOW: assert property (@(posedge core_clk) disable iff (reset)
    backup_active_flag |-> $past(cmp_in.main_below_trip)) else $error("backup with main above trip");
  AST_NO_COLD_BK: assert property (@(posedge core_clk) disable iff (reset)
    !main_valid_q |=> !backup_active_flag) else $error("backup before main was valid");
  AST_FLAG_LOW: assert property (@(posedge core_clk) disable iff (reset)
    (bk_q && cmp_in.main_above_cell && !cmp_in.cell_above_main) |=> !backup_active_flag)
    else $error("flag high while main above cell");
  AST_PIN_MATCH: assert property (@(posedge core_clk) disable iff (reset)
    reset_pin.level == ((VARIANT == SSRL_OUT_HIGH_OD) ? rst_q : ~rst_q))
    else $error("pin level disagrees with reset");
  // open-drain builds never drive high; the push-pull build always drives
  AST_PIN_DRIVE: assert property (@(posedge core_clk) disable iff (reset)
    (VARIANT == SSRL_OUT_LOW_PP) ? (reset_pin.oe && reset_pin.out == reset_pin.level)
      : (!reset_pin.out && reset_pin.oe == !reset_pin.level))
    else $error("pin drive does not fit the build");
  // release comes only after a full stretch, counted independently of hold_q
  AST_HOLD_FULL: assert property (@(posedge core_clk) disable iff (reset)
    $fell(rst_q) |-> stretch_q >= HW'(HOLD_CYC))
    else $error("reset released before the full hold period");
  AST_HOLD_RESTART: assert property (@(posedge core_clk) disable iff (reset)
    (st_q == SSRL_ST_HOLD && cause) |=> st_q == SSRL_ST_ACTIVE)
    else $error("cause during hold did not restart the stretch");
  AST_AUX_LOW: assert property (@(posedge core_clk) disable iff (reset)
    cmp_in.aux_low |=> rst_q)
    else $error("auxiliary low did not assert reset");
  AST_NO_SPURIOUS: assert property (@(posedge core_clk) disable iff (reset)
    (st_q == SSRL_ST_RUN && !cause && !wd_expire) |=> !rst_q)
    else $error("reset asserted with no cause and no expiry");
  AST_KICK_CLEARS: assert property (@(posedge core_clk) disable iff (reset)
    (st_q == SSRL_ST_RUN && !cause && !wd_expire && kick_clean != kick_prev_q) |=> wd_q == '0)
    else $error("kick edge left the watchdog counting");
  AST_WD_OFF: assert property (@(posedge core_clk) disable iff (reset)
    !watchdog_enable |=> wd_q == '0)
    else $error("watchdog counted while disabled");
  // filtered levels may only move to a level the raw input has held throughout
  AST_KICK_FILT: assert property (@(posedge core_clk) disable iff (reset)
    $changed(kick_clean) |-> ($past(watchdog_kick_input) == kick_clean &&
      $past(watchdog_kick_input, KICK_MIN_CYCLES) == kick_clean))
    else $error("kick accepted before its level stood long enough");
  AST_MR_FILT: assert property (@(posedge core_clk) disable iff (reset)
    $changed(mr_clean) |-> ($past(manual_reset_input) == mr_clean &&
      $past(manual_reset_input, DEB_CYC) == mr_clean))
    else $error("manual level accepted before debounce");
  AST_MR_STEADY: assert property (@(posedge core_clk) disable iff (reset)
    (mr_clean && manual_reset_input) |=> mr_clean)
    else $error("idle manual input caused a reset");
  AST_BK_SET: assert property (@(posedge core_clk) disable iff (reset)
    (main_valid_q && cmp_in.main_below_trip && cmp_in.cell_above_main) |=> backup_active_flag)
    else $error("no backup with main low and cell above");
  AST_BK_HOLD: assert property (@(posedge core_clk) disable iff (reset)
    (bk_q && cmp_in.main_below_trip && !cmp_in.cell_above_main && !cmp_in.main_above_cell) |=> backup_active_flag)
    else $error("backup dropped inside the hysteresis band");
  AST_CELL_OUT: assert property (@(posedge core_clk) disable iff (reset)
    !cmp_in.main_below_trip |=> !out_from_cell)
    else $error("switched supply on cell with main above trip");
  // the pin must already show reset at the first edge after the logic reset
  AST_RST_AT_RELEASE: assert property (@(posedge core_clk) disable iff (reset)
    $fell(reset) |-> (rst_q && reset_pin.level == (VARIANT == SSRL_OUT_HIGH_OD)))
    else $error("reset not shown after logic reset");
  AST_STATE_ONEHOT: assert property (@(posedge core_clk) disable iff (reset)
    $onehot(st_q))
    else $error("sequencer state lost its one-hot code");

endmodule : ssrl_top
`default_nettype wire
